// ===== rtl/fdc_map.svh
// Purpose: opcodes, field positions, reset values and counts of the
//          floppy command-phase handler
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH

// ----------------------------------------------------------------
// command codes and masks
// ----------------------------------------------------------------
`define OPC_SPECIFY      8'h03
`define OPC_SEEK         8'h0F
`define OPC_DUMP         8'h0E
`define OPC_PERP         8'h12
`define OPC_CONFIG       8'h13
`define OPC_LOCK         8'h14
`define OPC_LOCK_MASK    8'h7F
`define OPC_RELSEEK      8'h8F
`define OPC_RELSEEK_MASK 8'hBF
`define OPC_READID       8'h0A
`define OPC_READID_MASK  8'hBF
`define OPC_LOW5_MASK    8'h1F
`define OPC_READ         8'h06
`define OPC_READ_DEL     8'h0C
`define OPC_WRITE        8'h05
`define OPC_WRITE_DEL    8'h09
`define OPC_VERIFY       8'h16
`define OPC_READ_TRACK   8'h02
`define OPC_FORMAT       8'h0D

// ----------------------------------------------------------------
// parameter counts, result counts, field positions
// ----------------------------------------------------------------
`define NPAR_XFER        4'h8
`define NPAR_FORMAT      4'h5
`define NPAR_TWO         4'h2
`define NPAR_ONE         4'h1
`define NPAR_CONFIG      4'h3
`define NRES_DUMP        4'hA
`define NRES_XFER        4'h7
`define NRES_ONE         4'h1
`define POS_LOCK         7
`define POS_DIR          6
`define POS_HEAD         2
`define PAR_CYL          2
`define PAR_SC           3
`define PAR_EOT          6
`define STAT_INVALID     8'h80
`define RST_BYTE         8'h00

`endif

// ===== rtl/fdc_pkg.sv
// Purpose: types shared by the floppy command-phase handler
// Assumes: nothing
// Notes:   constants live in fdc_map.svh
package fdc_pkg;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_CMD,
		ST_PARAM,
		ST_SEEK,
		ST_EXEC,
		ST_LOAD,
		ST_SHOW
	} state_t;

	typedef enum logic [3:0] {
		K_INVALID,
		K_SPECIFY,
		K_SEEK,
		K_RELSEEK,
		K_DUMP,
		K_READID,
		K_PERP,
		K_CONFIG,
		K_LOCK,
		K_XFER,
		K_FORMAT
	} kind_t;

endpackage

// ===== rtl/result_store.sv
// Purpose: ten-byte result store with a registered read port
// Assumes: load and read do not fall in the same cycle
// Notes:   byte 0 sits in the low bits of load_data
`timescale 1ns/1ps
module result_store
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// parallel load
	input  wire logic        load,
	input  wire logic [79:0] load_data,
	// read port
	input  wire logic [3:0]  rd_idx,
	output logic      [7:0]  q
);
	logic [7:0] mem [0:9];

	// whole result written at once, so no fill sequence is needed
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < 10; i++)
				mem[i] <= 8'h00;
		end
		else if (load)
		begin
			for (int i = 0; i < 10; i++)
				mem[i] <= load_data[i*8 +: 8];
		end
	end

	// registered read; out-of-range index reads zero
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			q <= 8'h00;
		else if (rd_idx < 4'hA)
			q <= mem[rd_idx];
		else
			q <= 8'h00;
	end

endmodule

// ===== rtl/floppy_cmd_phase_handler.sv
// Purpose: command-phase interpreter of a floppy disk controller
// Assumes: host bytes and drive-side events are on clk already
// Notes:   drive select is driven out on seek_unit and op_unit
//
// Behaviour
// - dump gives sector count after format
// - dump gives end-of-track after read/write
// - drive-select bits go out on seek_unit and op_unit
// - transfer family shares one decode by bits 0-4
// - implied seek before transfer when enabled
// - drive busy flag set during seek
// - seek failure reported in transfer result
// - seek failure: seek status, two zero bytes, failing cylinder
// - unknown code: standby, single result 80h
// - read-id captures first valid sector id
// - read-id returns three status, then C,H,R,N
// - implied seek needs no host action
// - configure third byte sets fifo and seek options
`timescale 1ns/1ps
`include "fdc_map.svh"
module floppy_cmd_phase_handler
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// host command bytes
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_data,
	output logic            cmd_ready,
	// host result bytes
	output logic            res_valid,
	output logic      [7:0] res_data,
	input  wire logic       res_ready,
	// main status
	output logic            rqm,
	output logic            dio,
	output logic            cmd_busy,
	output logic      [3:0] drive_busy,
	output logic            standby,
	// configuration seen by the rest of the controller
	output logic            fifo_disable,
	output logic            polling_disable,
	output logic      [3:0] fifo_threshold,
	// seek logic
	output logic            seek_start,
	output logic      [1:0] seek_unit,
	output logic      [7:0] seek_target,
	input  wire logic       seek_done,
	input  wire logic       seek_fail,
	input  wire logic [7:0] seek_st0,
	input  wire logic [7:0] seek_fail_cyl,
	// execution engine
	output logic            op_start,
	output logic      [7:0] op_cmd,
	output logic      [1:0] op_unit,
	output logic            op_head,
	input  wire logic       op_done,
	input  wire logic [7:0] op_st0,
	input  wire logic [7:0] op_st1,
	input  wire logic [7:0] op_st2,
	input  wire logic [7:0] op_c,
	input  wire logic [7:0] op_h,
	input  wire logic [7:0] op_r,
	input  wire logic [7:0] op_n
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	fdc_pkg::state_t state_reg;
	fdc_pkg::state_t state_next;
	fdc_pkg::kind_t  kind_reg;
	fdc_pkg::kind_t  kind_in;
	logic [3:0] npar_in;
	logic [3:0] npar_reg;
	logic [3:0] pidx_reg;
	logic [7:0] par_reg [1:8];
	logic [7:0] pcn_reg [0:3];
	logic [7:0] tgt_reg;
	logic [7:0] spec1_reg, spec2_reg, perp_reg, cfg_reg, precomp_start_track_reg;
	logic [7:0] scot_reg;
	logic       last_fmt_reg, lock_reg, standby_reg;
	logic [3:0] rd_idx_reg, rcnt_reg, busy_reg;
	logic       take, last_par, need_seek;
	logic       exec_first_reg;
	logic       load_go;
	logic [79:0] load_vec;
	logic [3:0] load_cnt;
	logic [7:0] q;
	logic [1:0] unit;

	assign take      = cmd_valid && cmd_ready;
	assign last_par  = (state_reg == fdc_pkg::ST_PARAM) && take &&
		(pidx_reg == npar_reg);
	assign unit      = par_reg[1][1:0]; // also driven out on seek_unit and op_unit
	assign need_seek = cfg_reg[6] && (par_reg[`PAR_CYL] != pcn_reg[unit]);

	// ------------------------------------------------------------
	// first-byte decode
	// ------------------------------------------------------------
	always_comb
	begin
		kind_in = fdc_pkg::K_INVALID;
		npar_in = 4'h0;
		if ((cmd_data & `OPC_RELSEEK_MASK) == `OPC_RELSEEK)
		begin
			kind_in = fdc_pkg::K_RELSEEK;
			npar_in = `NPAR_TWO;
		end
		else if ((cmd_data & `OPC_LOCK_MASK) == `OPC_LOCK)
			kind_in = fdc_pkg::K_LOCK;
		else if ((cmd_data & `OPC_READID_MASK) == `OPC_READID)
		begin
			kind_in = fdc_pkg::K_READID;
			npar_in = `NPAR_ONE;
		end
		else if (cmd_data == `OPC_SPECIFY)
		begin
			kind_in = fdc_pkg::K_SPECIFY;
			npar_in = `NPAR_TWO;
		end
		else if (cmd_data == `OPC_SEEK)
		begin
			kind_in = fdc_pkg::K_SEEK;
			npar_in = `NPAR_TWO;
		end
		else if (cmd_data == `OPC_DUMP)
			kind_in = fdc_pkg::K_DUMP;
		else if (cmd_data == `OPC_PERP)
		begin
			kind_in = fdc_pkg::K_PERP;
			npar_in = `NPAR_ONE;
		end
		else if (cmd_data == `OPC_CONFIG)
		begin
			kind_in = fdc_pkg::K_CONFIG;
			npar_in = `NPAR_CONFIG;
		end
		else
		begin
			// upper bits carry mode flags; only bits 0-4 decode
			case (cmd_data & `OPC_LOW5_MASK)
				`OPC_READ, `OPC_READ_DEL, `OPC_WRITE, `OPC_WRITE_DEL,
				`OPC_VERIFY, `OPC_READ_TRACK:
				begin
					kind_in = fdc_pkg::K_XFER;
					npar_in = `NPAR_XFER;
				end
				`OPC_FORMAT:
				begin
					kind_in = fdc_pkg::K_FORMAT;
					npar_in = `NPAR_FORMAT;
				end
				default:
					kind_in = fdc_pkg::K_INVALID;
			endcase
		end
	end

	// ------------------------------------------------------------
	// result assembly, loaded into the store in one cycle
	// ------------------------------------------------------------
	always_comb
	begin
		load_go  = 1'b0;
		load_vec = 80'h0;
		load_cnt = 4'h0;
		if (state_reg == fdc_pkg::ST_CMD && take)
		begin
			case (kind_in)
				fdc_pkg::K_INVALID:
				begin
					load_go  = 1'b1;
					load_cnt = `NRES_ONE;
					load_vec[7:0] = `STAT_INVALID;
				end
				fdc_pkg::K_LOCK:
				begin
					load_go  = 1'b1;
					load_cnt = `NRES_ONE;
					load_vec[4] = cmd_data[`POS_LOCK];
				end
				fdc_pkg::K_DUMP:
				begin
					load_go  = 1'b1;
					load_cnt = `NRES_DUMP;
					load_vec = {precomp_start_track_reg, {1'b0, cfg_reg[6:0]},
						{lock_reg, 1'b0, perp_reg[5:0]}, scot_reg,
						spec2_reg, spec1_reg, pcn_reg[3], pcn_reg[2],
						pcn_reg[1], pcn_reg[0]};
				end
				default:
					load_go = 1'b0;
			endcase
		end
		else if (state_reg == fdc_pkg::ST_SEEK && seek_done &&
			seek_fail && kind_reg == fdc_pkg::K_XFER)
		begin
			// failure folds into the normal transfer result
			load_go  = 1'b1;
			load_cnt = `NRES_XFER;
			load_vec[55:0] = {par_reg[5], par_reg[4], par_reg[3],
				seek_fail_cyl, 8'h00, 8'h00, seek_st0};
		end
		else if (state_reg == fdc_pkg::ST_EXEC && op_done)
		begin
			// any executed command: status bytes, then C,H,R,N
			load_go  = 1'b1;
			load_cnt = `NRES_XFER;
			load_vec[55:0] = {op_n, op_r, op_h, op_c, op_st2, op_st1,
				op_st0};
		end
	end

	// ------------------------------------------------------------
	// phase sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			fdc_pkg::ST_CMD:
				if (take)
					state_next = load_go ? fdc_pkg::ST_LOAD :
						(npar_in == 4'h0) ? fdc_pkg::ST_CMD :
						fdc_pkg::ST_PARAM;
			fdc_pkg::ST_PARAM:
				if (last_par)
				begin
					case (kind_reg)
						fdc_pkg::K_SEEK, fdc_pkg::K_RELSEEK:
							state_next = fdc_pkg::ST_SEEK;
						fdc_pkg::K_XFER, fdc_pkg::K_FORMAT,
						fdc_pkg::K_READID:
							state_next = fdc_pkg::ST_EXEC;
						default:
							state_next = fdc_pkg::ST_CMD;
					endcase
				end
			fdc_pkg::ST_SEEK:
				if (seek_done)
					state_next = load_go ? fdc_pkg::ST_LOAD :
						(kind_reg == fdc_pkg::K_XFER) ?
						fdc_pkg::ST_EXEC : fdc_pkg::ST_CMD;
			fdc_pkg::ST_EXEC:
				if (exec_first_reg && kind_reg == fdc_pkg::K_XFER &&
					need_seek)
					state_next = fdc_pkg::ST_SEEK;
				else if (load_go)
					state_next = fdc_pkg::ST_LOAD;
			fdc_pkg::ST_LOAD:
				state_next = fdc_pkg::ST_SHOW;
			fdc_pkg::ST_SHOW:
				if (res_ready)
					state_next = (rd_idx_reg + 4'h1 == rcnt_reg) ?
						fdc_pkg::ST_CMD : fdc_pkg::ST_LOAD;
			default:
				state_next = fdc_pkg::ST_CMD;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			state_reg <= fdc_pkg::ST_CMD;
		else
			state_reg <= state_next;
	end

	// the seek check waits one cycle in exec, so C is already stored
	// and the host sends nothing extra for the seek
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			exec_first_reg <= 1'b0;
		else
			exec_first_reg <= last_par;
	end

	// ------------------------------------------------------------
	// command and parameter capture
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			kind_reg <= fdc_pkg::K_INVALID;
			npar_reg <= 4'h0;
			pidx_reg <= 4'h1;
			op_cmd   <= `RST_BYTE;
			for (int i = 1; i < 9; i++)
				par_reg[i] <= `RST_BYTE;
		end
		else if (state_reg == fdc_pkg::ST_CMD && take)
		begin
			kind_reg <= kind_in;
			npar_reg <= npar_in;
			pidx_reg <= 4'h1;
			op_cmd   <= cmd_data;
		end
		else if (state_reg == fdc_pkg::ST_PARAM && take)
		begin
			par_reg[pidx_reg[2:0] == 3'h0 ? 4'h8 : pidx_reg] <= cmd_data;
			pidx_reg <= pidx_reg + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// settings written by specify, perpendicular, configure, lock
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			spec1_reg  <= `RST_BYTE;
			spec2_reg  <= `RST_BYTE;
			perp_reg   <= `RST_BYTE;
			cfg_reg    <= `RST_BYTE;
			precomp_start_track_reg <= `RST_BYTE;
			lock_reg   <= 1'b0;
		end
		else if (state_reg == fdc_pkg::ST_CMD && take &&
			kind_in == fdc_pkg::K_LOCK)
			lock_reg <= cmd_data[`POS_LOCK];
		else if (last_par)
		begin
			case (kind_reg)
				fdc_pkg::K_SPECIFY:
				begin
					spec1_reg <= par_reg[1];
					spec2_reg <= cmd_data;
				end
				fdc_pkg::K_PERP:
					perp_reg <= cmd_data;
				fdc_pkg::K_CONFIG:
				begin
					cfg_reg    <= par_reg[2];
					precomp_start_track_reg <= cmd_data;
				end
				default:
					perp_reg <= perp_reg;
			endcase
		end
	end

	assign fifo_disable    = cfg_reg[5];
	assign polling_disable = cfg_reg[4];
	assign fifo_threshold  = cfg_reg[3:0];

	// ------------------------------------------------------------
	// sector-count or end-of-track, chosen by the last operation
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			scot_reg     <= `RST_BYTE;
			last_fmt_reg <= 1'b0;
		end
		else if (exec_first_reg && kind_reg == fdc_pkg::K_FORMAT)
		begin
			scot_reg     <= par_reg[`PAR_SC];
			last_fmt_reg <= 1'b1;
		end
		else if (exec_first_reg && kind_reg == fdc_pkg::K_XFER)
		begin
			scot_reg     <= par_reg[`PAR_EOT];
			last_fmt_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// seek launch, busy flags and present cylinders
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			seek_start <= 1'b0;
			tgt_reg    <= `RST_BYTE;
			busy_reg   <= 4'h0;
			for (int i = 0; i < 4; i++)
				pcn_reg[i] <= `RST_BYTE;
		end
		else
		begin
			seek_start <= 1'b0;
			if (last_par && (kind_reg == fdc_pkg::K_SEEK ||
				kind_reg == fdc_pkg::K_RELSEEK))
			begin
				seek_start <= 1'b1;
				busy_reg[unit] <= 1'b1;
				if (kind_reg == fdc_pkg::K_SEEK)
					tgt_reg <= cmd_data;
				else if (op_cmd[`POS_DIR])
					tgt_reg <= pcn_reg[unit] + cmd_data;
				else
					tgt_reg <= pcn_reg[unit] - cmd_data;
			end
			else if (state_reg == fdc_pkg::ST_EXEC && exec_first_reg &&
				kind_reg == fdc_pkg::K_XFER && need_seek)
			begin
				seek_start     <= 1'b1;
				tgt_reg        <= par_reg[`PAR_CYL];
				busy_reg[unit] <= 1'b1;
			end
			else if (state_reg == fdc_pkg::ST_SEEK && seek_done)
			begin
				busy_reg[unit] <= 1'b0;
				pcn_reg[unit]  <= seek_fail ? seek_fail_cyl : tgt_reg;
			end
		end
	end

	assign seek_unit   = unit;
	assign seek_target = tgt_reg;
	assign drive_busy  = busy_reg;
	assign op_unit     = unit;
	assign op_head     = par_reg[1][`POS_HEAD];

	// ------------------------------------------------------------
	// execution handoff; implied seek diverts to the seek state
	// ------------------------------------------------------------
	logic op_start_reg;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			op_start_reg <= 1'b0;
		else
			op_start_reg <= (state_reg == fdc_pkg::ST_EXEC &&
				exec_first_reg && !(kind_reg == fdc_pkg::K_XFER &&
				need_seek)) || (state_reg == fdc_pkg::ST_SEEK &&
				seek_done && !seek_fail && kind_reg == fdc_pkg::K_XFER);
	end
	assign op_start = op_start_reg;

	// an implied seek parks in the seek state and comes back to exec
	// only on a good seek_done, so busy and cylinder follow one path

	// ------------------------------------------------------------
	// result readout and standby
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rd_idx_reg  <= 4'h0;
			rcnt_reg    <= 4'h0;
			standby_reg <= 1'b0;
		end
		else
		begin
			if (load_go)
			begin
				rd_idx_reg <= 4'h0;
				rcnt_reg   <= load_cnt;
			end
			else if (state_reg == fdc_pkg::ST_SHOW && res_ready)
				rd_idx_reg <= rd_idx_reg + 4'h1;
			if (state_reg == fdc_pkg::ST_CMD && take)
				standby_reg <= (kind_in == fdc_pkg::K_INVALID);
		end
	end

	result_store u_store
	(
		.clk       (clk),
		.reset     (reset),
		.load      (load_go),
		.load_data (load_vec),
		.rd_idx    (rd_idx_reg),
		.q         (q)
	);

	assign res_data  = q;
	assign res_valid = (state_reg == fdc_pkg::ST_SHOW);
	assign cmd_ready = (state_reg == fdc_pkg::ST_CMD) ||
		(state_reg == fdc_pkg::ST_PARAM);
	assign rqm       = cmd_ready || res_valid;
	assign dio       = res_valid;
	assign cmd_busy  = (state_reg != fdc_pkg::ST_CMD);
	assign standby   = standby_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	invalid_result_a: assert property (
		state_reg == fdc_pkg::ST_CMD && take && kind_in == fdc_pkg::K_INVALID
		|-> ##2 res_valid && res_data == `STAT_INVALID && standby)
		else $error("invalid code result wrong");
	lock_result_a: assert property (
		state_reg == fdc_pkg::ST_CMD && take && kind_in == fdc_pkg::K_LOCK
		|-> ##2 res_valid && res_data == {3'b000, lock_reg, 4'b0000})
		else $error("lock result wrong");
	dump_first_a: assert property (
		state_reg == fdc_pkg::ST_CMD && take && kind_in == fdc_pkg::K_DUMP
		|-> ##2 res_valid && res_data == $past(pcn_reg[0], 2)
		&& rcnt_reg == `NRES_DUMP)
		else $error("dump result wrong");
	seek_busy_a: assert property (
		seek_start |-> ##1 (busy_reg[unit] &&
		state_reg == fdc_pkg::ST_SEEK))
		else $error("busy flag missing during seek");
	implied_seek_a: assert property (
		state_reg == fdc_pkg::ST_EXEC && exec_first_reg &&
		kind_reg == fdc_pkg::K_XFER && need_seek |-> ##1 seek_start
		&& seek_target == $past(par_reg[`PAR_CYL]) && !op_start)
		else $error("implied seek not launched");
	seek_fail_a: assert property (
		load_go && state_reg == fdc_pkg::ST_SEEK |-> ##2 res_valid &&
		res_data == $past(seek_st0, 2))
		else $error("seek failure status lost");
	readid_res_a: assert property (
		state_reg == fdc_pkg::ST_EXEC && op_done |-> ##2 res_valid &&
		res_data == $past(op_st0, 2) && rcnt_reg == `NRES_XFER)
		else $error("execution result wrong");
	fmt_sc_a: assert property (
		exec_first_reg && kind_reg == fdc_pkg::K_FORMAT |-> ##1
		last_fmt_reg && scot_reg == $past(par_reg[`PAR_SC]))
		else $error("sector count not kept");
	xfer_eot_a: assert property (
		exec_first_reg && kind_reg == fdc_pkg::K_XFER |-> ##1
		!last_fmt_reg && scot_reg == $past(par_reg[`PAR_EOT]))
		else $error("end of track not kept");

	dump_c: cover property (take && kind_in == fdc_pkg::K_DUMP &&
		state_reg == fdc_pkg::ST_CMD);
	implied_c: cover property (seek_start && kind_reg == fdc_pkg::K_XFER);
	fail_c: cover property (state_reg == fdc_pkg::ST_SEEK && seek_fail &&
		seek_done);
	readid_c: cover property (op_done && kind_reg == fdc_pkg::K_READID);

endmodule

// ===== test/drive_side_model.sv
// Purpose: behavioural seek logic and execution engine on the drive side
// Assumes: starts are one-cycle pulses from the handler
// Notes:   lat sets the answer delay, fail_seek makes seeks fail
`timescale 1ns/1ps
module drive_side_model
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// control from the bench
	input  wire logic       fail_seek,
	input  wire logic [3:0] lat,
	// seek logic
	input  wire logic       seek_start,
	output logic            seek_done,
	output logic            seek_fail,
	output logic      [7:0] seek_st0,
	output logic      [7:0] seek_fail_cyl,
	// execution engine
	input  wire logic       op_start,
	output logic            op_done,
	output logic      [7:0] op_st0,
	output logic      [7:0] op_st1,
	output logic      [7:0] op_st2,
	output logic      [7:0] op_c,
	output logic      [7:0] op_h,
	output logic      [7:0] op_r,
	output logic      [7:0] op_n
);
	logic       s_run;
	logic       o_run;
	logic [3:0] s_cnt;
	logic [3:0] o_cnt;

	// status is only valid with done; otherwise inverted so stale use shows
	assign seek_st0      = seek_done ? (seek_fail ? 8'h70 : 8'h20) : 8'h8F;
	assign seek_fail_cyl = seek_done ? 8'h4C : 8'hB3;
	assign {op_st0, op_st1, op_st2, op_c, op_h, op_r, op_n} = op_done ?
		56'h41_0203_3101_0702 : ~56'h41_0203_3101_0702;

	// answer lat+1 cycles after each start, launched off the falling edge
	always @(negedge clk or posedge reset)
	begin
		if (reset)
		begin
			{s_run, o_run, seek_done, seek_fail, op_done} <= 5'h00;
			s_cnt <= 4'h0;
			o_cnt <= 4'h0;
		end
		else
		begin
			seek_done <= 1'b0;
			op_done   <= 1'b0;
			if (seek_start)
			begin
				s_run <= 1'b1;
				s_cnt <= lat;
			end
			else if (s_run && s_cnt == 4'h0)
			begin
				s_run     <= 1'b0;
				seek_done <= 1'b1;
				seek_fail <= fail_seek;
			end
			else if (s_run)
				s_cnt <= s_cnt - 4'h1;
			if (op_start)
			begin
				o_run <= 1'b1;
				o_cnt <= lat;
			end
			else if (o_run && o_cnt == 4'h0)
			begin
				o_run   <= 1'b0;
				op_done <= 1'b1;
			end
			else if (o_run)
				o_cnt <= o_cnt - 4'h1;
		end
	end
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench of the command-phase handler
// Assumes: drive side answered by drive_side_model
// Notes:   inputs change on the falling clock edge
`timescale 1ns/1ps
module testbench;
	logic       clk;
	logic       reset;
	logic       cmd_valid;
	logic [7:0] cmd_data;
	logic       res_ready;
	logic       fail_seek;
	logic [3:0] lat;
	logic [7:0] ok_res [$];
	int         error_cnt;
	int         num_checks;
	wire        cmd_ready, res_valid, standby, fifo_disable, polling_disable;
	wire        seek_start, seek_done, seek_fail, op_start, op_done;
	wire        rqm, dio, cmd_busy, op_head;
	wire  [1:0] seek_unit, op_unit;
	wire  [7:0] op_cmd;
	wire  [3:0] drive_busy, fifo_threshold;
	wire  [7:0] res_data, seek_target, seek_st0, seek_fail_cyl;
	wire  [7:0] op_st0, op_st1, op_st2, op_c, op_h, op_r, op_n;

	floppy_cmd_phase_handler floppy_cmd_phase_handler_i (.clk(clk),
		.reset(reset), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .res_valid(res_valid), .res_data(res_data),
		.res_ready(res_ready), .rqm(rqm), .dio(dio), .cmd_busy(cmd_busy),
		.drive_busy(drive_busy), .standby(standby),
		.fifo_disable(fifo_disable), .polling_disable(polling_disable),
		.fifo_threshold(fifo_threshold), .seek_start(seek_start),
		.seek_unit(seek_unit), .seek_target(seek_target),
		.seek_done(seek_done), .seek_fail(seek_fail), .seek_st0(seek_st0),
		.seek_fail_cyl(seek_fail_cyl), .op_start(op_start), .op_cmd(op_cmd),
		.op_unit(op_unit), .op_head(op_head), .op_done(op_done),
		.op_st0(op_st0),
		.op_st1(op_st1), .op_st2(op_st2), .op_c(op_c), .op_h(op_h),
		.op_r(op_r), .op_n(op_n));

	drive_side_model drive_side_model_i (.clk(clk), .reset(reset),
		.fail_seek(fail_seek), .lat(lat), .seek_start(seek_start),
		.seek_done(seek_done), .seek_fail(seek_fail), .seek_st0(seek_st0),
		.seek_fail_cyl(seek_fail_cyl), .op_start(op_start),
		.op_done(op_done), .op_st0(op_st0), .op_st1(op_st1),
		.op_st2(op_st2), .op_c(op_c), .op_h(op_h), .op_r(op_r),
		.op_n(op_n));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		begin
			num_checks++;
			if (got !== exp)
			begin
				error_cnt++;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// valid stays up between bytes so it is never written twice per step
	task send(input logic [7:0] b [$]);
		int n;
		begin
			foreach (b[i])
			begin
				cmd_valid = 1'b1;
				cmd_data  = b[i];
				n = 0;
				while (cmd_ready !== 1'b1 && n < 200)
				begin
					@(negedge clk);
					n++;
				end
				// a byte never accepted counts as a mismatch here
				chk({7'h00, cmd_ready}, 8'h01);
				@(negedge clk);
			end
			cmd_valid = 1'b0;
		end
	endtask

	task results(input logic [7:0] e [$]);
		int n;
		begin
			foreach (e[i])
			begin
				n = 0;
				while (res_valid !== 1'b1 && n < 400)
				begin
					@(negedge clk);
					n++;
				end
				// status in result phase: request, read direction, busy
				chk({5'h00, rqm, dio, cmd_busy}, 8'h07);
				chk(res_data, e[i]);
				res_ready = 1'b1;
				@(negedge clk);
				res_ready = 1'b0;
			end
		end
	endtask

	task wait_seek(input logic [1:0] u, input logic [7:0] t);
		int n;
		begin
			n = 0;
			while (seek_start !== 1'b1 && n < 50)
			begin
				@(negedge clk);
				n++;
			end
			chk({7'h00, seek_start}, 8'h01);
			chk({6'h00, seek_unit}, {6'h00, u});
			chk(seek_target, t);
			chk({4'h0, drive_busy}, {4'h0, 4'h1 << u});
			// let an edge pass so a following send never rewrites valid
			@(negedge clk);
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_invalid_lock;
		begin
			send('{8'h00});
			results('{8'h80});
			chk({7'h00, standby}, 8'h01);
			send('{8'h94});
			results('{8'h10});
			send('{8'h14});
			results('{8'h00});
			chk({7'h00, standby}, 8'h00);
		end
	endtask

	task t_config;
		begin
			send('{8'h13, 8'h00, 8'h6A, 8'h05, 8'h03, 8'hAB, 8'hCD,
				8'h12, 8'h0B});
			chk({6'h00, fifo_disable, polling_disable}, 8'h02);
			chk({4'h0, fifo_threshold}, 8'h0A);
		end
	endtask

	// unit 1 throughout, as bits 0-1 of the first parameter byte select
	task t_seek;
		begin
			send('{8'h0F, 8'h01, 8'h20});
			wait_seek(2'd1, 8'h20);
			send('{8'hCF, 8'h01, 8'h05});
			wait_seek(2'd1, 8'h25);
			send('{8'h8F, 8'h01, 8'h03});
			wait_seek(2'd1, 8'h22);
			repeat (4) @(negedge clk);
			chk({4'h0, drive_busy}, 8'h00);
		end
	endtask

	task t_xfer;
		logic [7:0] ops [3];
		begin
			ops = '{8'h45, 8'hC9, 8'h16};
			send('{8'h06, 8'h01, 8'h30, 8'h00, 8'h01, 8'h02, 8'h12, 8'h1B,
				8'hFF});
			wait_seek(2'd1, 8'h30);
			results(ok_res);
			foreach (ops[i])
			begin
				send('{ops[i], 8'h01, 8'h30, 8'h00, 8'h01, 8'h02, 8'h12, 8'h1B,
					8'hFF});
				results(ok_res);
			end
		end
	endtask

	task t_dump(input logic [7:0] sc);
		begin
			send('{8'h0E});
			results('{8'h00, 8'h30, 8'h00, 8'h00, 8'hAB, 8'hCD, sc, 8'h0B,
				8'h6A, 8'h05});
		end
	endtask

	task t_format;
		begin
			send('{8'h0D, 8'h01, 8'h02, 8'h09, 8'h1B, 8'hE5});
			results(ok_res);
			t_dump(8'h09);
		end
	endtask

	// slow answer and a failing seek in mid-command
	task t_seek_fail;
		begin
			fail_seek = 1'b1;
			lat       = 4'h9;
			send('{8'h06, 8'h01, 8'h50, 8'h01, 8'h03, 8'h02, 8'h12, 8'h1B,
				8'hFF});
			wait_seek(2'd1, 8'h50);
			results('{8'h70, 8'h00, 8'h00, 8'h4C, 8'h01, 8'h03,
				8'h02});
			fail_seek = 1'b0;
			lat       = 4'h0;
		end
	endtask

	task t_readid;
		begin
			send('{8'h4A, 8'h04});
			results(ok_res);
			chk(op_cmd, 8'h4A);
			chk({5'h00, op_head, op_unit}, 8'h04);
		end
	endtask

	task report_and_stop;
		begin
			$display("checks %0d errors %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	// ------------------------------------------------------------
	// clock, main sequence, watchdog
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		{reset, cmd_valid, res_ready, fail_seek} = 4'h8;
		cmd_data   = 8'h00;
		lat        = 4'h2;
		error_cnt  = 0;
		num_checks = 0;
		ok_res     = '{8'h41, 8'h02, 8'h03, 8'h31, 8'h01, 8'h07, 8'h02};
		repeat (8) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		t_invalid_lock;
		t_config;
		t_seek;
		t_xfer;
		t_dump(8'h12);
		t_format;
		t_seek_fail;
		t_readid;
		report_and_stop;
	end

	// whole run needs a few hundred cycles; 20000 means a hang
	initial
	begin
		#80000;
		error_cnt++;
		report_and_stop;
	end
endmodule
